// ==== ffilt_defs.svh ====
`ifndef FFILT_DEFS_SVH
`define FFILT_DEFS_SVH

`define FFILT_NUM           12
`define FFILT_TBL_WORDS     768
`define FFILT_BASE_ADDR     16'h9000
`define FFILT_BASE_END      16'h97FC
`define FFILT_EXT_ADDR      16'h9A00
`define FFILT_EXT_END       16'h9DFC
`define FFILT_EXT_IDX       10'h200
`define FFILT_CTRL_ADDR     16'h8F00
`define FFILT_MQC_ADDR      16'h8F04
`define FFILT_STAT_ADDR     16'h8F08
`define FFILT_MASK_ADDR     16'h8F0C
`define FFILT_RES_ADDR      16'h8F10
`define FFILT_CTRL_STEER    16
`define FFILT_STAT_IMM      12
`define FFILT_RES_QUEUE     16
`define FFILT_RES_STEER     20
`define FFILT_RES_WIN       24
`define FFILT_LEN_LSB       0
`define FFILT_QUEUE_LSB     8
`define FFILT_PRIO_LSB      16
`define FFILT_IMM_BIT       24
`define FFILT_LAST_OFF      6'h3F
`define FFILT_MASK_OFF      2'h2
`define FFILT_WINDOW        16'h0080
`define FFILT_LEN_SLACK     17'h00008
`define FFILT_MQ_MODE_A     3'h2
`define FFILT_MQ_MODE_B     3'h0
`define FFILT_RESP_OKAY     2'h0
`define FFILT_RESP_SLVERR   2'h2
`define FFILT_RESET_WORD    32'h00000000

`endif

// ==== ffilt_match.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ffilt_defs.svh"

module ffilt_match
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// byte stream view
	input  wire logic        byte_valid_i,
	input  wire logic        sop_i,
	input  wire logic        eop_i,
	input  wire logic [15:0] byte_idx_i,
	input  wire logic [7:0]  data_i,
	// table view for this filter
	input  wire logic [7:0]  pattern_i,
	input  wire logic        mask_bit_i,
	input  wire logic [7:0]  length_i,
	input  wire logic        enable_i,
	// result, updated at end of packet
	output logic             match_o
);

	logic mism;
	logic in_window;
	logic cur_bad;
	logic short_pkt;

	// length also caps the window, but never beyond 128 bytes
	assign in_window = (byte_idx_i < `FFILT_WINDOW) && (byte_idx_i < {8'h00, length_i});
	assign cur_bad = in_window && mask_bit_i && (data_i != pattern_i);
	// byte_idx_i + 1 is the packet length at the last byte
	assign short_pkt = ({1'b0, byte_idx_i} + 17'h00001 + `FFILT_LEN_SLACK)
		< {9'h000, length_i};

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			mism <= 1'b0;
		else if (byte_valid_i)
			mism <= sop_i ? cur_bad : (mism | cur_bad);
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			match_o <= 1'b0;
		else if (byte_valid_i && eop_i)
			match_o <= enable_i && !short_pkt && !(cur_bad || (mism && !sop_i));
	end

endmodule
`default_nettype wire

// ==== ffilt_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none

module ffilt_monitor
(
	// clock and reset
	input wire logic                  CLK_I,
	input wire logic                  ARST_N_I,
	// stream and result
	input wire logic                  RX_VALID_I,
	input wire ffilt_pkg::ffilt_rx_t  RX_I,
	input wire logic                  RES_VALID_O,
	input wire ffilt_pkg::ffilt_res_t RES_O,
	// bus handshakes
	input wire logic                  AWVALID_I,
	input wire logic                  AWREADY_O,
	input wire logic                  WVALID_I,
	input wire logic                  WREADY_O,
	input wire logic                  BVALID_O,
	input wire logic                  BREADY_I,
	input wire logic                  ARVALID_I,
	input wire logic                  ARREADY_O,
	input wire logic                  RVALID_O,
	input wire logic                  RREADY_I
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!ARST_N_I);

	sequence s_wr_both;
		AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
	endsequence
	sequence s_pkt_end;
		RX_VALID_I && RX_I.last;
	endsequence

	a_wr_resp_time: assert property (s_wr_both |-> ##2 BVALID_O)
		else $error("write response not on time");
	a_rd_resp_time: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
		else $error("read data not on time");
	a_b_done: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
		else $error("write response repeated");
	a_wr_blocked: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
		else $error("write taken while response pending");
	a_rd_blocked: assert property (RVALID_O |-> !ARREADY_O)
		else $error("read taken while data pending");
	a_result_time: assert property (s_pkt_end |-> ##2 RES_VALID_O)
		else $error("packet result not on time");
	a_result_holds: assert property (!RES_VALID_O |-> $stable(RES_O))
		else $error("result changed without strobe");
	a_winner_matched: assert property (RES_VALID_O && RES_O.match != 12'h000
		|-> RES_O.match[RES_O.winner])
		else $error("winner did not match");
	a_no_match_quiet: assert property (RES_VALID_O && RES_O.match == 12'h000
		|-> !RES_O.steer && !RES_O.imm && RES_O.winner == 4'h0)
		else $error("action without any match");
endmodule

bind ffilt_top ffilt_monitor ffilt_monitor_i
(
	.CLK_I       (CLK_I),
	.ARST_N_I    (ARST_N_I),
	.RX_VALID_I  (RX_VALID_I),
	.RX_I        (RX_I),
	.RES_VALID_O (RES_VALID_O),
	.RES_O       (RES_O),
	.AWVALID_I   (AWVALID_I),
	.AWREADY_O   (AWREADY_O),
	.WVALID_I    (WVALID_I),
	.WREADY_O    (WREADY_O),
	.BVALID_O    (BVALID_O),
	.BREADY_I    (BREADY_I),
	.ARVALID_I   (ARVALID_I),
	.ARREADY_O   (ARREADY_O),
	.RVALID_O    (RVALID_O),
	.RREADY_I    (RREADY_I)
);
`default_nettype wire

// ==== ffilt_pkg.sv ====
package ffilt_pkg;

	typedef struct packed {
		logic       last;
		logic [7:0] data;
	} ffilt_rx_t;

	typedef struct packed {
		logic [11:0] match;
		logic        steer;
		logic [2:0]  queue;
		logic [3:0]  winner;
		logic        imm;
	} ffilt_res_t;

	typedef enum logic [1:0] {
		FFILT_WR_IDLE = 2'b01,
		FFILT_WR_RESP = 2'b10
	} ffilt_wr_state_t;

	typedef enum logic [1:0] {
		FFILT_RD_IDLE = 2'b01,
		FFILT_RD_RESP = 2'b10
	} ffilt_rd_state_t;

endpackage

// ==== ffilt_prio.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ffilt_defs.svh"

module ffilt_prio
(
	// per-filter inputs
	input  wire logic [11:0]     match_i,
	input  wire logic [11:0][2:0] prio_i,
	// winner
	output logic                 any_o,
	output logic [3:0]           winner_o
);

	logic [2:0] best;

	always_comb
	begin
		any_o = 1'b0;
		winner_o = 4'h0;
		best = 3'h0;
		for (int i = 0; i < `FFILT_NUM; i++)
		begin
			// strict compare keeps the lowest address on a tie
			if (match_i[i] && (!any_o || prio_i[i] > best))
			begin
				any_o = 1'b1;
				winner_o = 4'(i);
				best = prio_i[i];
			end
		end
	end

endmodule
`default_nettype wire

// ==== ffilt_rx_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module ffilt_rx_model
(
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            arst_n_i,
	// packet request
	input  wire logic            start_i,
	input  wire logic            slow_i,
	input  wire logic [7:0]      len_i,
	input  wire logic [7:0]      pkt_i [0:159],
	// byte stream
	output logic                 busy_o,
	output logic                 valid_o,
	output ffilt_pkg::ffilt_rx_t rx_o
);
	logic [7:0] idx;
	logic       gap;

	// slow mode leaves one idle cycle after each byte
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i)
		begin
			busy_o  <= 1'b0;
			valid_o <= 1'b0;
			rx_o    <= '0;
			idx     <= 8'h00;
			gap     <= 1'b0;
		end
		else if (busy_o && !(slow_i && gap))
		begin
			valid_o   <= 1'b1;
			rx_o.data <= pkt_i[idx];
			rx_o.last <= idx == len_i - 8'h01;
			busy_o    <= idx != len_i - 8'h01;
			idx       <= idx + 8'h01;
			gap       <= 1'b1;
		end
		else
		begin
			// idle lines invert every cycle, so the stale byte shows again every second idle cycle
			valid_o <= 1'b0;
			rx_o    <= ffilt_pkg::ffilt_rx_t'(~rx_o);
			gap     <= 1'b0;
			busy_o  <= busy_o || start_i;
			idx     <= busy_o ? idx : 8'h00;
		end
endmodule
`default_nettype wire

// ==== ffilt_top.sv ====
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ffilt_defs.svh"

module ffilt_top
(
	// clock and reset
	input  wire logic                 CLK_I,
	input  wire logic                 ARST_N_I,
	// power state, from logic on this clock
	input  wire logic                 POWER_D0_I,
	// receive byte stream
	input  wire logic                 RX_VALID_I,
	input  wire ffilt_pkg::ffilt_rx_t RX_I,
	// per-packet result
	output logic                      RES_VALID_O,
	output ffilt_pkg::ffilt_res_t     RES_O,
	// interrupt
	output logic                      IRQ_O,
	// axi4-lite write address
	input  wire logic [15:0]          AWADDR_I,
	input  wire logic                 AWVALID_I,
	output logic                      AWREADY_O,
	// axi4-lite write data
	input  wire logic [31:0]          WDATA_I,
	input  wire logic [3:0]           WSTRB_I,
	input  wire logic                 WVALID_I,
	output logic                      WREADY_O,
	// axi4-lite write response
	output logic [1:0]                BRESP_O,
	output logic                      BVALID_O,
	input  wire logic                 BREADY_I,
	// axi4-lite read address
	input  wire logic [15:0]          ARADDR_I,
	input  wire logic                 ARVALID_I,
	output logic                      ARREADY_O,
	// axi4-lite read data
	output logic [31:0]               RDATA_O,
	output logic [1:0]                RRESP_O,
	output logic                      RVALID_O,
	input  wire logic                 RREADY_I
);

	// returns {hit, word index}; extended table follows the base one
	function automatic logic [10:0] tbl_index(input logic [15:0] addr);
		logic [10:0] r;
		logic [15:0] ext_off;
		r = 11'h000;
		ext_off = addr - `FFILT_EXT_ADDR;
		if (addr >= `FFILT_BASE_ADDR && addr <= `FFILT_BASE_END)
			r = {2'b10, addr[10:2]};
		else if (addr >= `FFILT_EXT_ADDR && addr <= `FFILT_EXT_END)
			r = {1'b1, `FFILT_EXT_IDX + {2'b00, ext_off[9:2]}};
		return r;
	endfunction

	function automatic logic [31:0] apply_strb(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] r;
		r = old_w;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				r[8*b +: 8] = new_w[8*b +: 8];
		end
		return r;
	endfunction

	// word of filter f at offset off within its 64-word slice
	function automatic logic [9:0] fil_word(input logic [3:0] f, input logic [5:0] off);
		return {f, off};
	endfunction

	// table, contents undefined until software loads them
	logic [31:0] table_mem [0:`FFILT_TBL_WORDS-1];

	// control state
	logic [11:0] filter_n_enable;
	logic        queue_steering_enable;
	logic [2:0]  multi_queue_control;
	logic [12:0] int_status;
	logic [12:0] int_mask;
	logic [31:0] last_result;

	// axi state
	ffilt_pkg::ffilt_wr_state_t wr_state;
	ffilt_pkg::ffilt_rd_state_t rd_state;
	logic        aw_full;
	logic [15:0] aw_addr;
	logic        w_full;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic [10:0] wr_dec;
	logic [10:0] rd_dec;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic [31:0] ctrl_merged;
	logic [31:0] mask_merged;
	logic [31:0] w_lanes;

	// receive side
	logic        in_pkt;
	logic [15:0] byte_idx;
	logic        sop;
	logic        eop_take;
	logic        eop_d;
	logic        ops_en;
	logic [11:0] fil_match;
	logic [11:0][2:0] fil_prio;
	logic [11:0] fil_imm;
	logic [11:0][2:0] fil_queue;
	logic        any_match;
	logic [3:0]  winner;
	logic [12:0] next_events;

	// write channel: address and data are taken in either order
	assign AWREADY_O = !aw_full && (wr_state == ffilt_pkg::FFILT_WR_IDLE);
	assign WREADY_O = !w_full && (wr_state == ffilt_pkg::FFILT_WR_IDLE);
	assign do_write = aw_full && w_full && (wr_state == ffilt_pkg::FFILT_WR_IDLE);
	assign BVALID_O = (wr_state == ffilt_pkg::FFILT_WR_RESP);
	assign wr_dec = tbl_index(aw_addr);
	// a function result cannot be part-selected, so merge here
	assign ctrl_merged = apply_strb({20'h00000, filter_n_enable}, w_data, w_strb);
	assign mask_merged = apply_strb({19'h00000, int_mask}, w_data, w_strb);
	assign w_lanes = apply_strb(`FFILT_RESET_WORD, w_data, w_strb);

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			aw_full <= 1'b0;
			aw_addr <= 16'h0000;
		end
		else if (AWVALID_I && AWREADY_O)
		begin
			aw_full <= 1'b1;
			aw_addr <= AWADDR_I;
		end
		else if (do_write)
			aw_full <= 1'b0;
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			w_full <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else if (WVALID_I && WREADY_O)
		begin
			w_full <= 1'b1;
			w_data <= WDATA_I;
			w_strb <= WSTRB_I;
		end
		else if (do_write)
			w_full <= 1'b0;
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			wr_state <= ffilt_pkg::FFILT_WR_IDLE;
			BRESP_O <= `FFILT_RESP_OKAY;
		end
		else
		begin
			case (wr_state)
				ffilt_pkg::FFILT_WR_IDLE:
				begin
					if (do_write)
					begin
						wr_state <= ffilt_pkg::FFILT_WR_RESP;
						if (wr_dec[10] || aw_addr == `FFILT_CTRL_ADDR
							|| aw_addr == `FFILT_MQC_ADDR || aw_addr == `FFILT_STAT_ADDR
							|| aw_addr == `FFILT_MASK_ADDR || aw_addr == `FFILT_RES_ADDR)
							BRESP_O <= `FFILT_RESP_OKAY;
						else
							BRESP_O <= `FFILT_RESP_SLVERR;
					end
				end
				ffilt_pkg::FFILT_WR_RESP:
				begin
					if (BREADY_I)
						wr_state <= ffilt_pkg::FFILT_WR_IDLE;
				end
				default:
					wr_state <= ffilt_pkg::FFILT_WR_IDLE;
			endcase
		end
	end

	// no write lock: rewriting a live filter can misclassify a packet
	always_ff @(posedge CLK_I)
	begin
		if (do_write && wr_dec[10])
			table_mem[wr_dec[9:0]] <= apply_strb(table_mem[wr_dec[9:0]], w_data, w_strb);
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			filter_n_enable <= 12'h000;
			queue_steering_enable <= 1'b0;
			multi_queue_control <= 3'h0;
			int_mask <= 13'h0000;
		end
		else if (do_write)
		begin
			if (aw_addr == `FFILT_CTRL_ADDR)
			begin
				filter_n_enable <= ctrl_merged[11:0];
				if (w_strb[2])
					queue_steering_enable <= w_data[`FFILT_CTRL_STEER];
			end
			else if (aw_addr == `FFILT_MQC_ADDR)
			begin
				if (w_strb[0])
					multi_queue_control <= w_data[2:0];
			end
			else if (aw_addr == `FFILT_MASK_ADDR)
				int_mask <= mask_merged[12:0];
		end
	end

	// sticky status: a new event wins over a write-one clear
	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			int_status <= 13'h0000;
		else if (do_write && aw_addr == `FFILT_STAT_ADDR)
			int_status <= (int_status & ~w_lanes[12:0]) | next_events;
		else
			int_status <= int_status | next_events;
	end

	assign IRQ_O = |(int_status & int_mask);

	// read channel
	assign ARREADY_O = (rd_state == ffilt_pkg::FFILT_RD_IDLE);
	assign RVALID_O = (rd_state == ffilt_pkg::FFILT_RD_RESP);
	assign rd_dec = tbl_index(ARADDR_I);

	always_comb
	begin
		next_rdata = 32'h00000000;
		next_rresp = `FFILT_RESP_OKAY;
		if (rd_dec[10])
			next_rdata = table_mem[rd_dec[9:0]];
		else if (ARADDR_I == `FFILT_CTRL_ADDR)
		begin
			next_rdata[11:0] = filter_n_enable;
			next_rdata[`FFILT_CTRL_STEER] = queue_steering_enable;
		end
		else if (ARADDR_I == `FFILT_MQC_ADDR)
			next_rdata[2:0] = multi_queue_control;
		else if (ARADDR_I == `FFILT_STAT_ADDR)
			next_rdata[12:0] = int_status;
		else if (ARADDR_I == `FFILT_MASK_ADDR)
			next_rdata[12:0] = int_mask;
		else if (ARADDR_I == `FFILT_RES_ADDR)
			next_rdata = last_result;
		else
			next_rresp = `FFILT_RESP_SLVERR;
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			rd_state <= ffilt_pkg::FFILT_RD_IDLE;
			RDATA_O <= 32'h00000000;
			RRESP_O <= `FFILT_RESP_OKAY;
		end
		else
		begin
			case (rd_state)
				ffilt_pkg::FFILT_RD_IDLE:
				begin
					if (ARVALID_I)
					begin
						rd_state <= ffilt_pkg::FFILT_RD_RESP;
						RDATA_O <= next_rdata;
						RRESP_O <= next_rresp;
					end
				end
				ffilt_pkg::FFILT_RD_RESP:
				begin
					if (RREADY_I)
						rd_state <= ffilt_pkg::FFILT_RD_IDLE;
				end
				default:
					rd_state <= ffilt_pkg::FFILT_RD_IDLE;
			endcase
		end
	end

	// packet framing; the count saturates so huge frames stay long
	assign sop = !in_pkt;
	assign eop_take = RX_VALID_I && RX_I.last;

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			in_pkt <= 1'b0;
			byte_idx <= 16'h0000;
		end
		else if (RX_VALID_I)
		begin
			in_pkt <= !RX_I.last;
			if (RX_I.last)
				byte_idx <= 16'h0000;
			else if (byte_idx != 16'hFFFF)
				byte_idx <= byte_idx + 16'h0001;
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			eop_d <= 1'b0;
		else
			eop_d <= eop_take;
	end

	// first byte of a frame always sees index zero
	genvar f;
	generate
		for (f = 0; f < `FFILT_NUM; f++)
		begin : g_fil
			logic [15:0] idx;
			logic [31:0] pat_w;
			logic [31:0] mask_w;
			logic [31:0] last_w;
			assign idx = sop ? 16'h0000 : byte_idx;
			assign pat_w = table_mem[fil_word(4'(f), {idx[6:3], 1'b0, idx[2]})];
			assign mask_w = table_mem[fil_word(4'(f), {idx[6:3], `FFILT_MASK_OFF})];
			assign last_w = table_mem[fil_word(4'(f), `FFILT_LAST_OFF)];
			assign fil_prio[f] = last_w[`FFILT_PRIO_LSB +: 3];
			assign fil_queue[f] = last_w[`FFILT_QUEUE_LSB +: 3];
			assign fil_imm[f] = last_w[`FFILT_IMM_BIT];

			ffilt_match u_match
			(
				.clk_i        (CLK_I),
				.arst_n_i     (ARST_N_I),
				.byte_valid_i (RX_VALID_I),
				.sop_i        (sop),
				.eop_i        (RX_I.last),
				.byte_idx_i   (idx),
				.data_i       (RX_I.data),
				.pattern_i    (pat_w[8*idx[1:0] +: 8]),
				.mask_bit_i   (mask_w[idx[2:0]]),
				.length_i     (last_w[`FFILT_LEN_LSB +: 8]),
				.enable_i     (filter_n_enable[f]),
				.match_o      (fil_match[f])
			);
		end
	endgenerate

	ffilt_prio u_prio
	(
		.match_i  (fil_match),
		.prio_i   (fil_prio),
		.any_o    (any_match),
		.winner_o (winner)
	);

	assign ops_en = POWER_D0_I && queue_steering_enable && filter_n_enable[winner]
		&& (multi_queue_control == `FFILT_MQ_MODE_A
		|| multi_queue_control == `FFILT_MQ_MODE_B);

	always_comb
	begin
		next_events = 13'h0000;
		if (eop_d)
		begin
			next_events[11:0] = fil_match;
			next_events[`FFILT_STAT_IMM] = ops_en && |(fil_match & fil_imm);
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			RES_VALID_O <= 1'b0;
			RES_O <= '0;
			last_result <= 32'h00000000;
		end
		else
		begin
			RES_VALID_O <= eop_d;
			if (eop_d)
			begin
				RES_O.match <= fil_match;
				RES_O.steer <= any_match && ops_en;
				RES_O.queue <= fil_queue[winner];
				RES_O.winner <= winner;
				RES_O.imm <= next_events[`FFILT_STAT_IMM];
				last_result <= {4'h0, winner, 3'h0, any_match && ops_en,
					1'b0, fil_queue[winner], 4'h0, fil_match};
			end
		end
	end

endmodule
`default_nettype wire

// ==== flexible_packet_filter_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ffilt_defs.svh"

module flexible_packet_filter_tb;
	logic                  CLK_I      = 1'b0;
	logic                  ARST_N_I   = 1'b0;
	logic                  POWER_D0_I = 1'b0;
	logic                  AWVALID_I  = 1'b0;
	logic                  WVALID_I   = 1'b0;
	logic                  BREADY_I   = 1'b0;
	logic                  ARVALID_I  = 1'b0;
	logic                  RREADY_I   = 1'b0;
	logic [15:0]           AWADDR_I   = 16'h0000;
	logic [15:0]           ARADDR_I   = 16'h0000;
	logic [31:0]           WDATA_I    = 32'h00000000;
	logic [3:0]            WSTRB_I    = 4'hF;
	logic                  RX_VALID_I, RES_VALID_O, IRQ_O, AWREADY_O, WREADY_O;
	logic                  BVALID_O, ARREADY_O, RVALID_O, busy, ste;
	logic [1:0]            BRESP_O, RRESP_O;
	logic [31:0]           RDATA_O;
	ffilt_pkg::ffilt_rx_t  RX_I;
	ffilt_pkg::ffilt_res_t RES_O, lr;
	logic                  start = 1'b0;
	logic                  slow  = 1'b0;
	logic [7:0]            plen  = 8'h01;
	logic [7:0]            pat [0:159];
	logic [7:0]            pkt [0:159];
	logic [127:0]          msk [12];
	logic [7:0]            len [12];
	logic [2:0]            pri [12];
	logic [2:0]            que [12];
	logic [11:0]           en;
	logic [2:0]            mqc;
	logic [12:0]           stat = 13'h0000;
	logic [33:0]           q_b [$];
	logic [33:0]           q_r [$];
	logic [33:0]           q_s [$];
	int                    n_errors = 0;
	int                    n_tests  = 0;
	int                    cyc      = 0;

	ffilt_top ffilt_top_i
	(
		.CLK_I       (CLK_I),
		.ARST_N_I    (ARST_N_I),
		.POWER_D0_I  (POWER_D0_I),
		.RX_VALID_I  (RX_VALID_I),
		.RX_I        (RX_I),
		.RES_VALID_O (RES_VALID_O),
		.RES_O       (RES_O),
		.IRQ_O       (IRQ_O),
		.AWADDR_I    (AWADDR_I),
		.AWVALID_I   (AWVALID_I),
		.AWREADY_O   (AWREADY_O),
		.WDATA_I     (WDATA_I),
		.WSTRB_I     (WSTRB_I),
		.WVALID_I    (WVALID_I),
		.WREADY_O    (WREADY_O),
		.BRESP_O     (BRESP_O),
		.BVALID_O    (BVALID_O),
		.BREADY_I    (BREADY_I),
		.ARADDR_I    (ARADDR_I),
		.ARVALID_I   (ARVALID_I),
		.ARREADY_O   (ARREADY_O),
		.RDATA_O     (RDATA_O),
		.RRESP_O     (RRESP_O),
		.RVALID_O    (RVALID_O),
		.RREADY_I    (RREADY_I)
	);

	ffilt_rx_model ffilt_rx_model_i
	(
		.clk_i    (CLK_I),
		.arst_n_i (ARST_N_I),
		.start_i  (start),
		.slow_i   (slow),
		.len_i    (plen),
		.pkt_i    (pkt),
		.busy_o   (busy),
		.valid_o  (RX_VALID_I),
		.rx_o     (RX_I)
	);

	always #12.5 CLK_I = ~CLK_I;

	task automatic print_verdict;
		if (n_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// edge first, so back-to-back calls never drive a signal twice at once
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge CLK_I);
		q_b.push_back({32'h0, r});
		AWADDR_I  <= a;
		WDATA_I   <= d;
		AWVALID_I <= 1'b1;
		WVALID_I  <= 1'b1;
		BREADY_I  <= 1'b1;
		do
		begin
			@(posedge CLK_I);
			if (AWREADY_O)
				AWVALID_I <= 1'b0;
			if (WREADY_O)
				WVALID_I <= 1'b0;
		end
		while (BVALID_O !== 1'b1);
		BREADY_I <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge CLK_I);
		q_r.push_back({r, e});
		ARADDR_I  <= a;
		ARVALID_I <= 1'b1;
		RREADY_I  <= 1'b1;
		do
		begin
			@(posedge CLK_I);
			if (ARREADY_O)
				ARVALID_I <= 1'b0;
		end
		while (RVALID_O !== 1'b1);
		RREADY_I <= 1'b0;
	endtask

	function automatic logic [15:0] adr(input int f, input int w);
		return 16'((f < 8 ? 32'h9000 + f * 256 : 32'h9A00 + (f - 8) * 256) + w * 4);
	endfunction

	function automatic logic [31:0] word(input int f, input int w);
		int b;
		b = (w / 4) * 8 + (w % 2) * 4;
		if (w == 63)
			return {7'h0, f == 11, 5'h0, pri[f], 5'h0, que[f], len[f]};
		if (w % 4 == 2)
			return {24'h0, msk[f][(w / 4) * 8 +: 8]};
		if (w % 4 == 3)
			return 32'h0;
		return {pat[b + 3], pat[b + 2], pat[b + 1], pat[b]};
	endfunction

	// bytes past the packet end were never seen, so they cannot fail a filter
	function automatic logic hit(input int f, input int n);
		if (!en[f] || n + 8 < len[f])
			return 1'b0;
		for (int i = 0; i < len[f] && i < 128 && i < n; i++)
			if (msk[f][i] && pkt[i] !== pat[i])
				return 1'b0;
		return 1'b1;
	endfunction

	task automatic send(input int n);
		logic [11:0] m;
		logic [3:0]  w;
		logic        s;
		m = 12'h000;
		w = 4'h0;
		for (int f = 0; f < 12; f++)
		begin
			m[f] = hit(f, n);
			if (m[f] && (!m[w] || pri[f] > pri[w]))
				w = 4'(f);
		end
		s = |m && POWER_D0_I && ste && (mqc == 3'h0 || mqc == 3'h2);
		lr = '{m, s, que[w], w, s && m[11]};
		q_s.push_back({13'h0, lr});
		stat = stat | {lr.imm, m};
		slow  <= 1'($urandom);
		plen  <= 8'(n);
		start <= 1'b1;
		@(posedge CLK_I);
		start <= 1'b0;
		do
			@(posedge CLK_I);
		while (busy);
		repeat (3) @(posedge CLK_I);
	endtask

	always @(posedge CLK_I)
	begin
		cyc <= cyc + 1;
		if (BVALID_O === 1'b1 && BREADY_I)
			cmp("bresp", q_b.pop_front(), {32'h0, BRESP_O});
		if (RVALID_O === 1'b1 && RREADY_I)
			cmp("rdata", q_r.pop_front(), {RRESP_O, RDATA_O});
		if (RES_VALID_O === 1'b1)
			cmp("result", q_s.pop_front(), {13'h0, RES_O});
		if (cyc == 40000)
		begin
			n_errors++;
			print_verdict;
		end
	end

	initial
	begin
		void'($urandom(46061));
		for (int i = 0; i < 160; i++)
			pat[i] = 8'($urandom);
		for (int f = 0; f < 12; f++)
		begin
			len[f] = 8'(8 * (1 + $urandom % 16));
			pri[f] = (f == 11) ? 3'h7 : 3'($urandom % 7);
			que[f] = (f == 0) ? 3'h0 : 3'($urandom);
			msk[f] = {$urandom, $urandom, $urandom, $urandom};
		end
		repeat (12) @(posedge CLK_I);
		ARST_N_I <= 1'b1;
		rd(`FFILT_CTRL_ADDR, 32'h0, `FFILT_RESP_OKAY);
		rd(`FFILT_MASK_ADDR, 32'h0, `FFILT_RESP_OKAY);
		// filters stay disabled while the tables are written
		for (int f = 0; f < 12; f++)
			for (int w = 0; w < 64; w++)
				wr(adr(f, w), word(f, w), `FFILT_RESP_OKAY);
		rd(adr(9, 63), word(9, 63), `FFILT_RESP_OKAY);
		wr(16'h9800, 32'hFFFFFFFF, `FFILT_RESP_SLVERR);
		rd(16'h9800, 32'h0, `FFILT_RESP_SLVERR);
		for (int k = 0; k < 48; k++)
		begin
			en  = 12'($urandom);
			ste = 1'($urandom);
			mqc = 3'($urandom % 4);
			POWER_D0_I <= 1'($urandom);
			wr(`FFILT_CTRL_ADDR, {15'h0, ste, 4'h0, en}, `FFILT_RESP_OKAY);
			wr(`FFILT_MQC_ADDR, {29'h0, mqc}, `FFILT_RESP_OKAY);
			pkt = pat;
			for (int j = $urandom % 3; j > 0; j--)
				pkt[$urandom % 136] ^= 8'h01;
			send(1 + $urandom % 136);
		end
		rd(`FFILT_RES_ADDR, {4'h0, lr.winner, 3'h0, lr.steer, 1'h0, lr.queue, 4'h0, lr.match},
			`FFILT_RESP_OKAY);
		rd(`FFILT_STAT_ADDR, {19'h0, stat}, `FFILT_RESP_OKAY);
		cmp("irq", 34'h0, {33'h0, IRQ_O});
		wr(`FFILT_MASK_ADDR, 32'h00001FFF, `FFILT_RESP_OKAY);
		cmp("irq", {33'h0, |stat}, {33'h0, IRQ_O});
		wr(`FFILT_STAT_ADDR, {19'h0, stat}, `FFILT_RESP_OKAY);
		cmp("irq", 34'h0, {33'h0, IRQ_O});
		rd(`FFILT_STAT_ADDR, 32'h0, `FFILT_RESP_OKAY);
		print_verdict;
	end
endmodule
`default_nettype wire
